// *** rtl/lit_pkg.sv ***
package lit_pkg;

  // Clock and oscillator rates
  localparam int CLK_RATE_KHZ                  = 250000;
  localparam int INTERNAL_OSCILLATOR_RATE_KHZ  = 655;
  localparam int INTERNAL_OSCILLATOR_HALF_KHZ  = 327;
  // Fast oscillator period in system clocks, rounded down
  localparam int OSC_DIV = CLK_RATE_KHZ / INTERNAL_OSCILLATOR_RATE_KHZ;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CMD      = 6'h00;
  localparam logic [5:0] IDX_CTRL     = 6'h01;
  localparam logic [5:0] IDX_DATA_LO  = 6'h04;
  localparam logic [5:0] IDX_DATA_HI  = 6'h05;
  localparam logic [5:0] IDX_TIMER_LO = 6'h06;
  localparam logic [5:0] IDX_TIMER_HI = 6'h07;
  localparam logic [5:0] IDX_SYNC     = 6'h08;

  // Command register fields
  localparam int CMD_ENABLE_BIT = 7;
  localparam int CMD_PDOWN_BIT  = 6;
  localparam int CMD_MODE_BIT   = 5;
  localparam int CMD_SEL_LSB    = 2;
  localparam int CMD_WIDTH_LSB  = 0;
  // Control register fields
  localparam int CTRL_GAIN_LSB  = 2;

  // Field values
  localparam logic [1:0] SEL_LIGHT   = 2'h2;
  localparam logic [1:0] WIDTH_W16   = 2'h0;
  localparam logic [1:0] WIDTH_W12   = 2'h1;
  localparam logic [1:0] WIDTH_W8    = 2'h2;
  localparam logic [1:0] GAIN_RANGE2 = 2'h1;

  // Last cycle index of an internal integration
  localparam logic [15:0] LAST_W16 = 16'hffff;
  localparam logic [15:0] LAST_W12 = 16'h0fff;
  localparam logic [15:0] LAST_W8  = 16'h00ff;
  localparam logic [15:0] LAST_W4  = 16'h000f;
  // Largest light count: internal per width, then host
  localparam logic [15:0] MAX_N15  = 16'h8000;
  localparam logic [15:0] MAX_N11  = 16'h0800;
  localparam logic [15:0] MAX_N7   = 16'h0080;
  localparam logic [15:0] MAX_N3   = 16'h0008;
  localparam logic [15:0] MAX_EXT  = 16'hffff;

  // Reset values
  localparam logic [1:0] RST_WIDTH = 2'h0;
  localparam logic [1:0] RST_SEL   = 2'h0;
  localparam logic [1:0] RST_GAIN  = 2'h0;

  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_run  = 2'b01,
    ph_arr1 = 2'b10,
    ph_arr2 = 2'b11
  } lit_phase_e;

endpackage : lit_pkg

// *** rtl/lit_osc_gen.sv ***
`timescale 1ns/100ps
module lit_osc_gen #(
  parameter int DIV = lit_pkg::OSC_DIV
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic half_i,
  output logic      tick_o
);

  localparam int CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] div;
    logic          ph;
    logic          tick;
  } lit_osc_s;

  lit_osc_s st;
  lit_osc_s next_st;
  logic     fast;

  // Same divider in both timing modes; only gain halves it
  always_comb begin
    next_st = st;
    fast    = (st.div == CW'(DIV - 1));
    next_st.div = fast ? '0 : st.div + CW'(1);  // [R10]
    if (fast) begin
      next_st.ph = ~st.ph;
    end
    next_st.tick = fast && (!half_i || st.ph);  // [R03]
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;

  a_half_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [R03]
    fast && half_i && !st.ph |=> !tick_o)
    else $error("half speed tick not skipped");

endmodule : lit_osc_gen

// *** rtl/lit_cycle_counter.sv ***
`timescale 1ns/100ps
module lit_cycle_counter #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         clr_i,
  input  wire logic         tick_i,
  output logic      [W-1:0] count_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } lit_cnt_s;

  lit_cnt_s st;
  lit_cnt_s next_st;

  // Clear wins; holds at full scale rather than wrapping
  always_comb begin
    next_st = st;
    if (clr_i) begin
      next_st.cnt = '0;  // [R17]
    end else if (tick_i && (st.cnt != {W{1'b1}})) begin
      next_st.cnt = st.cnt + W'(1);  // [R08]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_o = st.cnt;

  a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R08]
    (st.cnt == {W{1'b1}}) && !clr_i |=> st.cnt == {W{1'b1}})
    else $error("cycle counter wrapped");

endmodule : lit_cycle_counter

// *** rtl/lit_timing.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// [R01] Internal mode ends each integration after exactly 2^m oscillator cycles.
// [R02] One mode bit in the command register picks internal or host timing.
// [R03] Gain ranges one and two run the converter clock at half rate.
// [R04] Host mode needs three sync commands per new readable count; here only the first count takes three, each later count two.
// [R05] First sync starts array one; second ends it and starts array two.
// [R06] Third sync ends array two, publishes count, restarts array one.
// [R07] Host spaces syncs equally; period is the sum of both gaps.
// [R08] Host mode cycle counter is capped at 65,536 cycles; the counter here holds at 65,535.
// [R09] Host keeps integrations under 65,535 cycles so counter never overflows.
// [R10] Oscillator behaves the same in both timing modes.
// [R11] Internal mode light count tops out at 2^n, n from width.
// [R12] Host mode publishes the cycle total as full-scale reference.
// [R13] Width 00,01,10,11 gives 65,536, 4,096, 256, 16 cycles.
// [R14] Mode bit clear means internal timing, set means host timing; clear default.
// [R15] Gain is bits 3 and 2 of the control register, ranges one to four.
// [R16] Cycle total reads only in host mode, low and high byte.
// [R17] Counter clears when integration starts, captured when count publishes.
module lit_timing #(
  parameter int AW      = 8,
  parameter int OSC_DIV = lit_pkg::OSC_DIV
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [AW-1:0] paddr_i,
  input  wire logic [31:0]   pwdata_i,
  input  wire logic          light_pulse_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  output logic               integrating_o,
  output logic               publish_o
);

  typedef struct packed {
    logic                enable;
    logic                pdown;
    logic                mode;
    logic [1:0]          sel;
    logic [1:0]          width;
    logic [1:0]          gain;
    lit_pkg::lit_phase_e phase;
    logic [15:0]         acc;
    logic [15:0]         data;
    logic [15:0]         timer;
    logic                pub;
    logic                integ;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } lit_state_s;

  lit_state_s  st;
  lit_state_s  next_st;
  logic        tick;
  logic [15:0] cyc;
  logic        cyc_clr;
  logic        active;
  logic        access;
  logic        wr;
  logic        sync;
  logic        mapped;
  logic [5:0]  idx;
  logic [15:0] cap;
  logic        switching;

  // Last cycle index for a width code
  function automatic logic [15:0] lit_last(input logic [1:0] w);
    if (w == lit_pkg::WIDTH_W16) begin
      return lit_pkg::LAST_W16;  // [R13]
    end else if (w == lit_pkg::WIDTH_W12) begin
      return lit_pkg::LAST_W12;
    end else if (w == lit_pkg::WIDTH_W8) begin
      return lit_pkg::LAST_W8;
    end else begin
      return lit_pkg::LAST_W4;
    end
  endfunction : lit_last

  // Largest internal light count for a width code
  function automatic logic [15:0] lit_max(input logic [1:0] w);
    if (w == lit_pkg::WIDTH_W16) begin
      return lit_pkg::MAX_N15;  // [R11]
    end else if (w == lit_pkg::WIDTH_W12) begin
      return lit_pkg::MAX_N11;
    end else if (w == lit_pkg::WIDTH_W8) begin
      return lit_pkg::MAX_N7;
    end else begin
      return lit_pkg::MAX_N3;
    end
  endfunction : lit_max

  lit_osc_gen #(
    .DIV (OSC_DIV)
  ) u_osc (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .half_i (st.gain <= lit_pkg::GAIN_RANGE2),  // [R03]
    .tick_o (tick)
  );

  lit_cycle_counter #(
    .W (16)
  ) u_cnt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clr_i   (cyc_clr),
    .tick_i  (tick),
    .count_o (cyc)
  );

  always_comb begin
    next_st = st;
    next_st.pub = 1'b0;
    cyc_clr = 1'b0;
    active  = st.enable && !st.pdown && (st.sel == lit_pkg::SEL_LIGHT);
    access  = psel_i && penable_i;
    idx     = paddr_i[7:2];
    mapped  = (paddr_i[1:0] == 2'b00) && ((paddr_i >> 8) == '0);
    if (!((idx <= lit_pkg::IDX_CTRL) || ((idx >= lit_pkg::IDX_DATA_LO) && (idx <= lit_pkg::IDX_SYNC)))) begin
      mapped = 1'b0;
    end
    wr   = access && st.pready && pwrite_i && mapped;
    sync = wr && (idx == lit_pkg::IDX_SYNC);
    switching = wr && (idx == lit_pkg::IDX_CMD) && (pwdata_i[lit_pkg::CMD_MODE_BIT] != st.mode);
    // Internal count saturates at 2^n; host count at full 16 bits
    cap  = st.mode ? lit_pkg::MAX_EXT : lit_max(st.width);  // [R11]

    // Integration sequencing
    if (!active) begin
      next_st.phase = lit_pkg::ph_idle;
      next_st.acc   = '0;
      cyc_clr       = 1'b1;
    end else if (!st.mode) begin  // [R14]
      if (st.phase != lit_pkg::ph_run) begin
        next_st.phase = lit_pkg::ph_run;
        next_st.acc   = '0;
        cyc_clr       = 1'b1;  // [R17]
      end else if (tick && (cyc == lit_last(st.width))) begin
        next_st.data = (light_pulse_i && (st.acc != cap)) ? st.acc + 16'h0001 : st.acc;  // [R01]
        next_st.acc  = '0;
        next_st.pub  = 1'b1;
        cyc_clr      = 1'b1;
      end else if (tick && light_pulse_i && (st.acc != cap)) begin
        next_st.acc = st.acc + 16'h0001;
      end
    end else begin
      // Sync pulse edge drops a coincident light pulse; one count at most
      case (st.phase)
        lit_pkg::ph_idle, lit_pkg::ph_run: begin
          if (sync) begin
            next_st.phase = lit_pkg::ph_arr1;  // [R05]
            next_st.acc   = '0;
            cyc_clr       = 1'b1;  // [R17]
          end
        end
        lit_pkg::ph_arr1: begin
          if (sync) begin
            next_st.phase = lit_pkg::ph_arr2;  // [R05]
          end else if (tick && light_pulse_i && (st.acc != cap)) begin
            next_st.acc = st.acc + 16'h0001;
          end
        end
        lit_pkg::ph_arr2: begin
          if (sync) begin
            next_st.phase = lit_pkg::ph_arr1;  // [R06]
            next_st.data  = st.acc;  // [R04]
            next_st.timer = cyc;  // [R12]
            next_st.pub   = 1'b1;
            next_st.acc   = '0;
            cyc_clr       = 1'b1;  // [R17]
          end else if (tick && light_pulse_i && (st.acc != cap)) begin
            next_st.acc = st.acc + 16'h0001;
          end
        end
        default: begin
          next_st.phase = lit_pkg::ph_idle;
        end
      endcase
    end

    // APB slave: one wait state, write lands with pready
    next_st.pready  = access && !st.pready;
    next_st.pslverr = access && !st.pready && !mapped;
    if (access && !st.pready) begin
      next_st.prdata = '0;
      if (!mapped || pwrite_i) begin
        next_st.prdata = '0;
      end else if (idx == lit_pkg::IDX_CMD) begin
        next_st.prdata[lit_pkg::CMD_ENABLE_BIT]                  = st.enable;
        next_st.prdata[lit_pkg::CMD_PDOWN_BIT]                   = st.pdown;
        next_st.prdata[lit_pkg::CMD_MODE_BIT]                    = st.mode;
        next_st.prdata[lit_pkg::CMD_SEL_LSB+:2]                  = st.sel;
        next_st.prdata[lit_pkg::CMD_WIDTH_LSB+:2]                = st.width;
      end else if (idx == lit_pkg::IDX_CTRL) begin
        next_st.prdata[lit_pkg::CTRL_GAIN_LSB+:2] = st.gain;  // [R15]
      end else if (idx == lit_pkg::IDX_DATA_LO) begin
        next_st.prdata[7:0] = st.data[7:0];
      end else if (idx == lit_pkg::IDX_DATA_HI) begin
        next_st.prdata[7:0] = st.data[15:8];
      end else if (idx == lit_pkg::IDX_TIMER_LO) begin
        next_st.prdata[7:0] = st.mode ? st.timer[7:0] : 8'h00;  // [R16]
      end else if (idx == lit_pkg::IDX_TIMER_HI) begin
        next_st.prdata[7:0] = st.mode ? st.timer[15:8] : 8'h00;  // [R16]
      end
    end

    if (wr && (idx == lit_pkg::IDX_CMD)) begin
      next_st.enable = pwdata_i[lit_pkg::CMD_ENABLE_BIT];
      next_st.pdown  = pwdata_i[lit_pkg::CMD_PDOWN_BIT];
      next_st.mode   = pwdata_i[lit_pkg::CMD_MODE_BIT];  // [R02]
      next_st.sel    = pwdata_i[lit_pkg::CMD_SEL_LSB+:2];
      next_st.width  = pwdata_i[lit_pkg::CMD_WIDTH_LSB+:2];
      // Switching mode abandons the running integration
      if (switching) begin
        next_st.phase = lit_pkg::ph_idle;  // [R02]
        next_st.acc   = '0;
        // Nothing published, but data keeps its last count and still takes an internal end on this cycle
        next_st.pub   = 1'b0;
        cyc_clr       = 1'b1;
      end
    end else if (wr && (idx == lit_pkg::IDX_CTRL)) begin
      next_st.gain = pwdata_i[lit_pkg::CTRL_GAIN_LSB+:2];  // [R15]
    end

    // Decoded here so the pin leaves a flop directly
    next_st.integ = (next_st.phase != lit_pkg::ph_idle);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st       <= '0;
      st.sel   <= lit_pkg::RST_SEL;
      st.width <= lit_pkg::RST_WIDTH;
      st.gain  <= lit_pkg::RST_GAIN;
      st.mode  <= 1'b0;  // [R14]
      st.phase <= lit_pkg::ph_idle;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o      = st.prdata;
  assign pready_o      = st.pready;
  assign pslverr_o     = st.pslverr;
  assign integrating_o = st.integ;
  assign publish_o     = st.pub;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_in_arr2;
    active && st.mode && (st.phase == lit_pkg::ph_arr2) && sync;
  endsequence

  sequence s_restart;
    (st.phase == lit_pkg::ph_arr1) && st.pub && (cyc == 16'h0000);
  endsequence

  a_int_end_count: assert property ( // [R01]
    active && !st.mode && (st.phase == lit_pkg::ph_run) && tick && (cyc == lit_last(st.width)) && !switching
    |=> st.pub && (cyc == 16'h0000))
    else $error("internal integration end missed");

  a_mode_switch: assert property ( // [R02]
    $changed(st.mode) |-> (st.phase == lit_pkg::ph_idle))
    else $error("mode change did not restart");

  a_three_syncs: assert property ( // [R04]
    st.pub && st.mode |-> $past(st.phase) == lit_pkg::ph_arr2)
    else $error("host count published early");

  a_sync_start: assert property ( // [R05]
    active && st.mode && (st.phase == lit_pkg::ph_idle) && sync
    |=> (st.phase == lit_pkg::ph_arr1) && (cyc == 16'h0000) && !st.pub)
    else $error("first sync did not start array one");

  a_sync_end: assert property ( // [R06]
    s_in_arr2 |=> s_restart)
    else $error("third sync did not publish and restart");

  a_int_max: assert property ( // [R11]
    !st.mode && st.pub |-> st.data <= lit_max(st.width))
    else $error("internal count above full scale");

  a_timer_capture: assert property ( // [R12]
    s_in_arr2 |=> st.timer == $past(cyc))
    else $error("cycle total not captured");

  a_timer_hidden: assert property ( // [R16]
    access && !st.pready && !pwrite_i && !st.mode && (paddr_i == AW'(4 * lit_pkg::IDX_TIMER_LO))
    |=> pready_o && (prdata_o == 32'h0000_0000))
    else $error("timer readable in internal mode");

  sequence s_apb_wait;
    access && !st.pready;
  endsequence

  sequence s_apb_done;
    pready_o ##1 !pready_o;
  endsequence

  a_apb_answer: assert property (
    s_apb_wait |=> s_apb_done)
    else $error("apb answer not one wait state");

  a_sync_second: assert property ( // [R05]
    active && st.mode && (st.phase == lit_pkg::ph_arr1) && sync
    |=> (st.phase == lit_pkg::ph_arr2) && !st.pub)
    else $error("second sync did not start array two");

  a_idle_clear: assert property ( // [R17]
    !active |=> (st.phase == lit_pkg::ph_idle) && (st.acc == 16'h0000) && (cyc == 16'h0000))
    else $error("stopped converter kept counting");

  a_switch_quiet: assert property ( // [R02]
    switching |=> !st.pub && (st.phase == lit_pkg::ph_idle) && (cyc == 16'h0000))
    else $error("mode switch published or kept running");

  a_mode_write: assert property ( // [R02]
    wr && (idx == lit_pkg::IDX_CMD) |=> st.mode == $past(pwdata_i[lit_pkg::CMD_MODE_BIT]))
    else $error("mode bit not written");

  a_gain_write: assert property ( // [R15]
    wr && (idx == lit_pkg::IDX_CTRL) |=> st.gain == $past(pwdata_i[lit_pkg::CTRL_GAIN_LSB+:2]))
    else $error("gain field not written");

  a_timer_hidden_hi: assert property ( // [R16]
    access && !st.pready && !pwrite_i && !st.mode && (paddr_i == AW'(4 * lit_pkg::IDX_TIMER_HI))
    |=> pready_o && (prdata_o == 32'h0000_0000))
    else $error("timer high byte readable in internal mode");

  a_pub_single: assert property (
    st.pub |=> !st.pub)
    else $error("publish pulse longer than one cycle");

  a_bad_addr: assert property (
    access && !st.pready && !mapped |=> pready_o && pslverr_o && (prdata_o == 32'h0000_0000))
    else $error("unmapped access not refused");

endmodule : lit_timing

// *** verif/lit_host_model.sv ***
`timescale 1ns/100ps
module lit_host_model (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  output logic             hung_o
);
  int cyc = 0;
  int slot = 0;

  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
    hung_o = 1'b0;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
  end

  // Request held until pready seen; one idle edge after release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 50);
    if (n >= 50) begin
      hung_o <= 1'b1;
    end
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~d;
    @(posedge clk_i);
  endtask : xfer

  // Sync commands on a fixed grid, so both gaps match
  // Caller keeps gap far below the counter limit
  task automatic sync_slot(input int gap);
    logic [31:0] q;
    logic        err;
    if (slot == 0) begin
      slot = cyc;
    end
    while (cyc < slot) begin
      @(posedge clk_i);
    end
    slot = slot + gap;
    xfer(1'b1, {lit_pkg::IDX_SYNC, 2'b00}, 32'h0000_0000, q, err);
  endtask : sync_slot
endmodule : lit_host_model

// *** verif/tb_light_integration_timing.sv ***
`timescale 1ns/100ps
module tb_light_integration_timing;
  localparam int DIV = 4;
  localparam int GAP = 200;
  localparam int TK  = 2 * GAP / DIV;
  logic        clk_i;
  logic        rst_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        light;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        integ;
  logic        pub;
  logic        hung;
  logic [31:0] q;
  logic [31:0] ql;
  logic        err;
  int          mismatches = 0;
  int          tests_run = 0;
  int          pubs = 0;
  int          pubs0;
  int          n;

  lit_timing #(.AW(8), .OSC_DIV(DIV)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .light_pulse_i(light), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .integrating_o(integ), .publish_o(pub));

  lit_host_model host (
    .clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .hung_o(hung));

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : expect_eq

  task automatic expect_in(input logic [31:0] got, input int lo, input int hi);
    tests_run++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: got %0d, outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : expect_in

  task automatic bail();
    mismatches++;
    tally_and_finish();
  endtask : bail

  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    host.xfer(wr, {idx, 2'b00}, d, q, err);
    if (hung === 1'b1) begin
      bail();
    end
  endtask : xfer

  // Low byte first; both read before the next publish
  task automatic rd16(input logic [5:0] idx);
    xfer(1'b0, idx, 32'h0000_0000);
    ql = q;
    xfer(1'b0, idx + 6'h01, 32'h0000_0000);
    q = {16'h0000, q[7:0], ql[7:0]};
  endtask : rd16

  task automatic wait_pub();
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pub !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      bail();
    end
  endtask : wait_pub

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (pub === 1'b1) begin
      pubs <= pubs + 1;
    end
  end

  initial begin
    rst_i = 1'b1;
    light = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    light <= 1'b1;
    xfer(1'b0, lit_pkg::IDX_CMD, 32'h0000_0000);
    expect_eq(q, 32'h0000_0000);
    xfer(1'b0, 6'h02, 32'h0000_0000);
    expect_eq({31'h0, err}, 32'h0000_0001);
    // Range one: first period discarded after setup
    xfer(1'b1, lit_pkg::IDX_CMD, 32'h0000_008b);
    wait_pub();
    wait_pub();
    expect_eq(n, 16 * DIV * 2);
    xfer(1'b1, lit_pkg::IDX_CTRL, 32'h0000_000c);
    xfer(1'b0, lit_pkg::IDX_CTRL, 32'h0000_0000);
    expect_eq(q, 32'h0000_000c);
    // Widths grow, so a running count never passes the new end
    for (int w = 3; w >= 1; w--) begin
      xfer(1'b1, lit_pkg::IDX_CMD, 32'h0000_0088 | w);
      wait_pub();
      wait_pub();
      expect_eq(n, (16 << (4 * (3 - w))) * DIV);
      rd16(lit_pkg::IDX_DATA_LO);
      expect_eq(q, 8 << (4 * (3 - w)));
      rd16(lit_pkg::IDX_TIMER_LO);
      expect_eq(q, 32'h0000_0000);
    end
    xfer(1'b1, lit_pkg::IDX_CMD, 32'h0000_00a8);
    repeat (2) @(posedge clk_i);
    expect_eq({31'h0, integ}, 32'h0000_0000);
    pubs0 = pubs;
    for (int i = 1; i <= 5; i++) begin
      host.sync_slot(GAP);
      if (hung === 1'b1) begin
        bail();
      end
      if (i == 1) begin
        expect_eq({31'h0, integ}, 32'h0000_0001);
      end
      if (i == 2) begin
        expect_eq(pubs - pubs0, 0);
      end
      if (i == 3 || i == 5) begin
        repeat (3) @(posedge clk_i);
        expect_eq(pubs - pubs0, (i - 1) / 2);
        expect_eq({31'h0, integ}, 32'h0000_0001);
        rd16(lit_pkg::IDX_TIMER_LO);
        expect_in(q, TK - 1, TK + 1);
        rd16(lit_pkg::IDX_DATA_LO);
        expect_in(q, TK - 3, TK + 1);
      end
    end
    tally_and_finish();
  end
endmodule : tb_light_integration_timing
